// ===== hdl/host_port_pkg.sv
// Package: constants and carriers for the host bus port and bank decode
package host_port_pkg;
  // ----------------------------------------
  // Address space
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 3;
  localparam int LOC_W = 9;
  localparam int BANK_LSB = 9;
  localparam int BANK_COUNT = 8;
  localparam logic [ADDR_W-1:0] GLOBAL_LO = 12'h000;
  localparam logic [ADDR_W-1:0] GLOBAL_HI = 12'h007;
  localparam logic [ADDR_W-1:0] LINE1_LO = 12'h400;
  localparam logic [ADDR_W-1:0] LINE1_HI = 12'h406;
  localparam logic [ADDR_W-1:0] FRAMER1_LO = 12'h600;
  localparam logic [ADDR_W-1:0] FRAMER1_HI = 12'h6a6;
  localparam logic [ADDR_W-1:0] FRAMER1_LO2 = 12'h6e0;
  localparam logic [ADDR_W-1:0] FRAMER1_HI2 = 12'h6ff;
  localparam logic [ADDR_W-1:0] LINK1_LO = 12'h800;
  localparam logic [ADDR_W-1:0] LINK1_HI = 12'h80e;
  localparam logic [ADDR_W-1:0] LINE2_LO = 12'ha00;
  localparam logic [ADDR_W-1:0] LINE2_HI = 12'ha06;
  localparam logic [ADDR_W-1:0] FRAMER2_LO = 12'hc00;
  localparam logic [ADDR_W-1:0] FRAMER2_HI = 12'hca6;
  localparam logic [ADDR_W-1:0] FRAMER2_LO2 = 12'hce0;
  localparam logic [ADDR_W-1:0] FRAMER2_HI2 = 12'hcff;
  localparam logic [ADDR_W-1:0] LINK2_LO = 12'he00;
  localparam logic [ADDR_W-1:0] LINK2_HI = 12'he0e;
  localparam logic [ADDR_W-1:0] GLOBAL_INT_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] GLOBAL_CFG4_ADDR = 12'h004;
  localparam int INT_POL_BIT = 6;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int REF_KHZ = 2048;
  localparam int REF_DIV = (CLK_MHZ * 1000) / (2 * REF_KHZ);
  localparam int REF_W = 6;
  localparam int NO_WAIT_MHZ = 33;
  localparam int ABSENT_LIMIT = 64;
  localparam int ABS_W = 7;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef enum logic [2:0] {
    BANK_GLOBAL, BANK_RESERVED, BANK_LINE1, BANK_FRAMER1,
    BANK_LINK1, BANK_LINE2, BANK_FRAMER2, BANK_LINK2
  } bank_type;
  typedef struct packed {
    logic bus_mux;
    logic strobe_rw;
    logic chip_sel_n;
    logic addr_latch;
    logic write_or_data_strobe_n;
    logic rd_rw;
    logic [ADDR_W-1:0] addr_pins;
    logic [DATA_W-1:0] ad_pins;
  } host_pins_type;
  typedef struct packed {
    logic valid;
    logic write;
    bank_type bank;
    logic [LOC_W-1:0] loc;
    logic in_range;
    logic [DATA_W-1:0] wdata;
  } reg_access_type;
endpackage

// ===== hdl/sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sync3
  import host_port_pkg::*;
#(
  parameter int WIDTH = 1,
  // Idle level of each pin, so that leaving reset shows no false edge or strobe
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_type;
  sync_state_type state;
  sync_state_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.s1 = async_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    // Only bits where stages two and three agree move
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state.s2[i] == state.s3[i])
      begin
        next_state.level[i] = state.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= '{s1: RESET_VALUE, s2: RESET_VALUE, s3: RESET_VALUE, level: RESET_VALUE};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign level_out = state.level;
endmodule

// ===== hdl/host_bus_port.sv
// Host bus port: strobe modes, bank decode, acknowledge and interrupt timing
`timescale 1ns/1ps
module host_bus_port
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Host bus pins
  input wire host_pins_type pins_in,
  input wire logic host_bus_clock_in,
  input wire logic [DATA_W-1:0] read_data_in,
  output logic [DATA_W-1:0] ad_out,
  output logic ad_oe_n_out,
  output logic ready_ack_out,
  output logic ready_ack_oe_n_out,
  // Interrupt timing and alarm sources
  input wire logic recovered_line_clock_in,
  input wire logic alarm_event_in,
  input wire logic alarm_status_read_in,
  output logic interrupt_out,
  // Register access toward the blocks
  output reg_access_type access_out,
  output logic stray_write_out
);
  // ----------------------------------------
  // Synchronised pins
  // ----------------------------------------
  localparam int SYNC_W = $bits(host_pins_type) + 4;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {host_pins_type'{chip_sel_n: 1'b1, write_or_data_strobe_n: 1'b1, rd_rw: 1'b1, default: '0}, 4'h0};
  logic [SYNC_W-1:0] sync_level;
  host_pins_type p;
  logic host_bus_clock_s;
  logic rlck_s;
  logic alarm_s;
  logic stat_rd_s;

  sync3 #(.WIDTH(SYNC_W), .RESET_VALUE(SYNC_IDLE)) pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({pins_in, host_bus_clock_in, recovered_line_clock_in, alarm_event_in, alarm_status_read_in}),
    .level_out(sync_level)
  );
  assign p = sync_level[SYNC_W-1:4];
  assign host_bus_clock_s = sync_level[3];
  assign rlck_s = sync_level[2];
  assign alarm_s = sync_level[1];
  assign stat_rd_s = sync_level[0];

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic in_span(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                   input logic [ADDR_W-1:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic addr_defined(input logic [ADDR_W-1:0] a);
    addr_defined = in_span(a, GLOBAL_LO, GLOBAL_HI)
      || in_span(a, LINE1_LO, LINE1_HI) || in_span(a, LINE2_LO, LINE2_HI)
      || in_span(a, FRAMER1_LO, FRAMER1_HI) || in_span(a, FRAMER1_LO2, FRAMER1_HI2)
      || in_span(a, FRAMER2_LO, FRAMER2_HI) || in_span(a, FRAMER2_LO2, FRAMER2_HI2)
      || in_span(a, LINK1_LO, LINK1_HI) || in_span(a, LINK2_LO, LINK2_HI);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {IDLE, ACTIVE, DONE} phase_type;
  typedef struct packed {
    phase_type phase;
    logic [ADDR_W-1:0] addr;
    logic as_prev;
    logic host_bus_clock_prev;
    logic rlck_prev;
    logic alarm_prev;
    logic [REF_W-1:0] ref_cnt;
    logic [ABS_W-1:0] absent_cnt;
    logic [ABS_W-1:0] host_absent_cnt;
    logic int_pol_low;
    logic int_pending;
    logic int_level;
    logic global_read;
    logic ack;
    logic ack_drive;
    logic [DATA_W-1:0] rdata;
    logic data_drive;
    reg_access_type acc;
    logic stray;
  } port_state_type;
  port_state_type s;
  port_state_type next_s;

  logic strobe_on;
  logic cycle_write;
  logic [ADDR_W-1:0] cur_addr;
  logic int_tick;

  always_comb
  begin
    next_s = s;
    next_s.as_prev = p.addr_latch;
    next_s.host_bus_clock_prev = host_bus_clock_s;
    next_s.rlck_prev = rlck_s;
    next_s.alarm_prev = alarm_s;
    next_s.acc.valid = 1'b0;
    if (p.strobe_rw)
    begin
      strobe_on = !p.chip_sel_n && (!p.write_or_data_strobe_n || !p.rd_rw);
      cycle_write = !p.write_or_data_strobe_n;
    end
    else
    begin
      strobe_on = !p.chip_sel_n && !p.write_or_data_strobe_n;
      cycle_write = !p.rd_rw;
    end
    // muxed address latched on falling strobe, split bus enabled while low
    if (p.bus_mux)
    begin
      if (s.as_prev && !p.addr_latch)
      begin
        next_s.addr = {p.addr_pins[ADDR_W-1:DATA_W], p.ad_pins};
      end
      cur_addr = s.addr;
    end
    else
    begin
      cur_addr = p.addr_pins;
    end
    case (s.phase)
      IDLE:
      begin
        if (strobe_on)
        begin
          next_s.phase = ACTIVE;
          next_s.acc.valid = 1'b1;
          next_s.acc.write = cycle_write;
          // bank from top bits, location from low bits
          next_s.acc.bank = bank_type'(cur_addr[ADDR_W-1:BANK_LSB]);
          next_s.acc.loc = cur_addr[LOC_W-1:0];
          next_s.acc.in_range = addr_defined(cur_addr);
          next_s.acc.wdata = p.ad_pins;
          next_s.rdata = cycle_write ? ZERO_BYTE : read_data_in;
          next_s.data_drive = !cycle_write;
          next_s.global_read = !cycle_write && cur_addr == GLOBAL_INT_ADDR;
          if (cycle_write && cur_addr == GLOBAL_CFG4_ADDR)
          begin
            next_s.int_pol_low = p.ad_pins[INT_POL_BIT];
          end
          // nonzero writes to bank one or to undefined addresses flagged as stray
          if (cycle_write && (!addr_defined(cur_addr) || cur_addr[ADDR_W-1:BANK_LSB] == BANK_W'(BANK_RESERVED))
              && p.ad_pins != ZERO_BYTE)
          begin
            next_s.stray = 1'b1;
          end
        end
      end
      ACTIVE:
      begin
        next_s.phase = DONE;
      end
      DONE:
      begin
        if (!strobe_on)
        begin
          next_s.phase = IDLE;
          next_s.data_drive = 1'b0;
        end
      end
      default:
      begin
        next_s.phase = IDLE;
      end
    endcase
    next_s.ack_drive = !p.chip_sel_n;
    if (p.strobe_rw)
    begin
      // ready raised on a host clock rising edge, at once when no host clock runs
      if (s.phase == DONE && strobe_on && (host_bus_clock_s && !s.host_bus_clock_prev || s.host_absent_cnt == ABS_W'(ABSENT_LIMIT)))
        next_s.ack = 1'b1;
      else if (!strobe_on)
        next_s.ack = 1'b0;
    end
    else
    begin
      // acknowledge follows chip select and data strobe once the cycle has left IDLE
      next_s.ack = s.phase != IDLE && strobe_on;
    end
    // line clock presence watchdog and fallback tick every REF_DIV (24) cycles, about 4.17 MHz
    if (rlck_s != s.rlck_prev)
      next_s.absent_cnt = '0;
    else if (s.absent_cnt != ABS_W'(ABSENT_LIMIT))
      next_s.absent_cnt = s.absent_cnt + 1'b1;
    if (host_bus_clock_s != s.host_bus_clock_prev)
      next_s.host_absent_cnt = '0;
    else if (s.host_absent_cnt != ABS_W'(ABSENT_LIMIT))
      next_s.host_absent_cnt = s.host_absent_cnt + 1'b1;
    next_s.ref_cnt = (s.ref_cnt == REF_W'(REF_DIV - 1)) ? '0 : s.ref_cnt + 1'b1;
    int_tick = (s.absent_cnt == ABS_W'(ABSENT_LIMIT)) ? s.ref_cnt == '0 : (rlck_s && !s.rlck_prev);
    // one assertion per alarm activation, set wins over clear
    if (alarm_s && !s.alarm_prev)
    begin
      next_s.int_pending = 1'b1;
    end
    else if (s.global_read && stat_rd_s)
    begin
      next_s.int_pending = 1'b0;
      next_s.global_read = 1'b0;
    end
    // interrupt level changes only on the timing tick; a polarity write moves the pin at once
    if (int_tick)
    begin
      next_s.int_level = s.int_pending;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ad_out = s.rdata;
  assign ad_oe_n_out = !s.data_drive;
  // ready active high, acknowledge active low
  assign ready_ack_out = p.strobe_rw ? s.ack : !s.ack;
  assign ready_ack_oe_n_out = !s.ack_drive;
  assign interrupt_out = s.int_level ^ s.int_pol_low;
  assign access_out = s.acc;
  assign stray_write_out = s.stray;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  bank_index_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s.acc.valid |-> s.acc.bank == bank_type'($past(cur_addr[ADDR_W-1:BANK_LSB])))
    else $error("bank index mismatch");
  global_range_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s.acc.valid && s.acc.bank == BANK_GLOBAL && s.acc.loc <= LOC_W'(GLOBAL_HI) |-> s.acc.in_range)
    else $error("global register not decoded");
  reserved_bank_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s.acc.valid && s.acc.bank == BANK_RESERVED |-> !s.acc.in_range)
    else $error("reserved bank decoded");
  int_polarity_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(s.int_pol_low) |-> $past(s.phase == IDLE && strobe_on && cycle_write && cur_addr == GLOBAL_CFG4_ADDR))
    else $error("interrupt polarity wrong");
  no_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s.acc.valid |=> s.phase == DONE)
    else $error("access not finished");
  ack_strobe_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !p.strobe_rw && !strobe_on |=> !s.ack)
    else $error("acknowledge held without strobe");
  ready_clock_a: assert property (@(posedge clk_in) disable iff (rst_in)
    p.strobe_rw && $rose(s.ack) |-> $past(host_bus_clock_s) && !$past(s.host_bus_clock_prev) || $past(s.host_absent_cnt) == ABS_W'(ABSENT_LIMIT))
    else $error("ready not on host clock edge");
  int_tick_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(s.int_level) |-> $past(int_tick))
    else $error("interrupt moved off tick");
endmodule

// ===== testbench/host_model.sv
// Host processor model that runs single bus cycles on the port pins
`timescale 1ns/1ps
module host_model
  import host_port_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Mode straps
  input wire logic mux_in,
  input wire logic rw_in,
  // Port pins
  input wire logic [DATA_W-1:0] ad_in,
  input wire logic ad_oe_n_in,
  input wire logic ready_ack_in,
  input wire logic ready_ack_oe_n_in,
  output host_pins_type pins_out
);
  host_pins_type p;
  logic drv;
  initial
  begin
    p = '0;
    p.chip_sel_n = 1'b1;
    p.write_or_data_strobe_n = 1'b1;
    p.rd_rw = 1'b1;
    drv = 1'b0;
  end
  // mode straps
  // Released bus shows the inverse of the last byte, so stale data never matches
  always_comb
  begin
    pins_out = p;
    pins_out.bus_mux = mux_in;
    pins_out.strobe_rw = rw_in;
    pins_out.ad_pins = drv ? p.ad_pins : (ad_oe_n_in ? ~p.ad_pins : ad_in);
  end
  // strobes low, cycle stretched until ready or acknowledge
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input int slow, output logic [DATA_W-1:0] q);
    int n;
    q = 'x;
    @(posedge clk_in);
    p.addr_pins <= mux_in ? {a[11:8], 8'h00} : a;
    p.ad_pins <= mux_in ? a[7:0] : d;
    drv <= mux_in | wr;
    p.addr_latch <= mux_in;
    p.rd_rw <= rw_in | !wr;
    p.chip_sel_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    p.addr_latch <= 1'b0;
    repeat (6) @(posedge clk_in);
    p.ad_pins <= d;
    drv <= wr;
    p.write_or_data_strobe_n <= !(wr | !rw_in);
    if (rw_in && !wr)
      p.rd_rw <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (!(ready_ack_oe_n_in === 1'b0 && ready_ack_in === rw_in) && n < 80);
    if (n < 80)
      q = ad_in;
    repeat (slow) @(posedge clk_in);
    p.write_or_data_strobe_n <= 1'b1;
    p.rd_rw <= rw_in | !wr;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ready_ack_in === rw_in && n < 80);
    p.chip_sel_n <= 1'b1;
    drv <= 1'b0;
    // Deselect must outlast the pin filter, or the port never sees it
    repeat (3) @(posedge clk_in);
  endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the host bus port and bank decode
`timescale 1ns/1ps
module tb
  import host_port_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_in;
  logic rst_in;
  logic host_clk;
  logic line_clk;
  logic line_on = 1'b0;
  logic mux;
  logic rw;
  logic alarm;
  logic status_rd;
  logic [DATA_W-1:0] rd_byte;
  logic [DATA_W-1:0] ad;
  logic ad_oe_n;
  logic rdy;
  logic rdy_oe_n;
  logic irq;
  logic stray;
  host_pins_type pins;
  reg_access_type acc;
  reg_access_type seen;
  logic [DATA_W-1:0] q;
  int mismatches = 0;
  int comparisons = 0;
  int valid_count = 0;
  // bank one only read; out-of-range cells only read
  logic [13:0] rows [22] = '{
    {12'h000, 2'b11}, {12'h007, 2'b11}, {12'h008, 2'b00}, {12'h200, 2'b00}, {12'h3ff, 2'b00},
    {12'h400, 2'b11}, {12'h406, 2'b11}, {12'h407, 2'b00}, {12'h600, 2'b11}, {12'h6a6, 2'b11},
    {12'h6a7, 2'b00}, {12'h6e0, 2'b11}, {12'h6ff, 2'b11}, {12'h800, 2'b11}, {12'h80e, 2'b11},
    {12'h80f, 2'b00}, {12'ha06, 2'b11}, {12'hc00, 2'b11}, {12'hca6, 2'b11}, {12'hce0, 2'b11},
    {12'he0e, 2'b11}, {12'he0f, 2'b00}};
  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  host_bus_port i_host_bus_port (.clk_in(clk_in), .rst_in(rst_in), .pins_in(pins), .host_bus_clock_in(host_clk),
    .read_data_in(rd_byte), .ad_out(ad), .ad_oe_n_out(ad_oe_n), .ready_ack_out(rdy),
    .ready_ack_oe_n_out(rdy_oe_n), .recovered_line_clock_in(line_clk), .alarm_event_in(alarm),
    .alarm_status_read_in(status_rd), .interrupt_out(irq), .access_out(acc), .stray_write_out(stray));
  host_model i_host_model (.clk_in(clk_in), .mux_in(mux), .rw_in(rw), .ad_in(ad), .ad_oe_n_in(ad_oe_n),
    .ready_ack_in(rdy), .ready_ack_oe_n_in(rdy_oe_n), .pins_out(pins));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // host clock slow enough for the pin filter; its edges avoid the sampling edge
  initial
  begin
    host_clk = 1'b0;
    forever #30 host_clk = ~host_clk;
  end
  // line clock stands still until line_on is raised
  initial
  begin
    line_clk = 1'b0;
    forever #40 line_clk = line_on & ~line_clk;
  end
  always @(posedge clk_in)
    if (acc.valid === 1'b1)
    begin
      seen <= acc;
      valid_count <= valid_count + 1;
    end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic inr, input int slow);
    int count_at_start;
    count_at_start = valid_count;
    i_host_model.access(wr, a, d, slow, q);
    check_value(16'(valid_count - count_at_start), 16'h0001);
    check_value(16'(seen.bank), 16'(a[11:9]));
    check_value(16'(seen.loc), 16'(a[8:0]));
    check_flag(seen.in_range, inr);
    check_flag(seen.write, wr);
    if (wr)
      check_value(16'(seen.wdata), 16'(d));
    else
      check_value(16'(q), 16'(rd_byte));
  endtask
  task automatic reset_check;
    // Let the pin filter settle, so a false strobe after reset would show
    repeat (4) @(posedge clk_in);
    check_flag(irq, 1'b0);
    check_flag(stray, 1'b0);
    check_flag(ad_oe_n, 1'b1);
    check_flag(rdy_oe_n, 1'b1);
  endtask
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
    check_flag(irq, e);
  endtask
  task automatic results;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    rst_in = 1'b1;
    mux = 1'b0;
    rw = 1'b0;
    alarm = 1'b0;
    status_rd = 1'b0;
    rd_byte = 8'ha5;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    reset_check();
    foreach (rows[i])
      run(rows[i][1], rows[i][13:2], 8'h5a, rows[i][0], 0);
    check_flag(stray, 1'b0);
    rw <= 1'b1;
    run(1'b0, 12'h406, 8'h00, 1'b1, 3);
    run(1'b1, 12'h6ff, 8'h3c, 1'b1, 0);
    mux <= 1'b1;
    rw <= 1'b0;
    run(1'b1, 12'h80e, 8'h00, 1'b1, 2);
    rw <= 1'b1;
    run(1'b0, 12'ha00, 8'h00, 1'b1, 0);
    mux <= 1'b0;
    rw <= 1'b0;
    run(1'b1, 12'h008, 8'h11, 1'b0, 0);
    check_flag(stray, 1'b1);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    reset_check();
    alarm <= 1'b1;
    wait_irq(1'b1);
    run(1'b0, GLOBAL_INT_ADDR, 8'h00, 1'b1, 0);
    check_flag(irq, 1'b1);
    status_rd <= 1'b1;
    repeat (4) @(posedge clk_in);
    status_rd <= 1'b0;
    wait_irq(1'b0);
    alarm <= 1'b0;
    run(1'b1, GLOBAL_CFG4_ADDR, 8'h40, 1'b1, 0);
    wait_irq(1'b1);
    line_on <= 1'b1;
    alarm <= 1'b1;
    wait_irq(1'b0);
    results();
  end
  // Generous span: twenty-nine accesses of some forty cycles plus interrupt waits
  initial
  begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    results();
  end
endmodule
